// ---- include/ldsr_pkg.sv ----
/*
 Constants, types and field layouts for the LED driver serial status register block.
 Assumes one 50 MHz clock and a host that runs the two-wire bus well below that rate.
*/
// Behaviour
// - Send Byte, Receive Byte, Read and Write Byte/Word transfers are all served.
// - Registers change either by bus writes or by internal logic, per type.
// - A read of any mapped register returns its present value.
// - Bus writes to read-only registers leave them untouched.
// - Strap sampled once after reset; own address compared after every start.
// - Address mismatch: stay silent, no acknowledge, until the next start.
// - Direction bit after the address: 1 reads, 0 writes.
// - Bus framing follows the two-wire system management bus, version 2.0 on.
// - Four read-only drain level registers sit at indices 00h to 03h.
// - Drain level is an unsigned byte, MSB in bit 7, 256 steps over 8 V.
// - Index 04h holds anode level, unsigned byte, 256 steps over 67.9 V.
// - Bits 7 and 6 of 05h are writable unused flags that mask string faults.
// - Acknowledge of an unused-flag write comes only after masking is in force.
// - 05h bits 5 and 2 show overvoltage of strings 1 and 2.
// - 05h bits 3 and 0 read back unused status of strings 1 and 2.
// - 05h and 06h carry status of strings 1-2 and 3-4; 07h carries faults.
// - Strap picks 0101100 grounded, 0101110 open, 0101111 tied high.
// - Address fills the upper seven bits of the first byte, direction the LSB.
// - Registers are one byte wide and reserved bits read zero.
package ldsr_pkg;
   // Register indices
   localparam logic [3:0] REG_DRAIN1  = 4'h0;
   localparam logic [3:0] REG_DRAIN4  = 4'h3;
   localparam logic [3:0] REG_ANODE   = 4'h4;
   localparam logic [3:0] REG_PAIR_A  = 4'h5;
   localparam logic [3:0] REG_PAIR_B  = 4'h6;
   localparam logic [3:0] REG_FAULT   = 4'h7;
   localparam logic [3:0] REG_PEAK    = 4'h8;
   // Unused flag positions inside a pair status byte
   localparam int         POS_FIRST_UNUSED  = 7;
   localparam int         POS_SECOND_UNUSED = 6;
   // Reset values
   localparam logic [3:0] RST_UNUSED  = 4'h0;
   localparam logic [7:0] RST_PEAK    = 8'h7F;
   // Strap codes and the slave addresses they select
   localparam logic [1:0] STRAP_GND   = 2'h0;
   localparam logic [1:0] STRAP_VDD   = 2'h2;
   localparam logic [6:0] ADDR_GND    = 7'h2C;
   localparam logic [6:0] ADDR_OPEN   = 7'h2E;
   localparam logic [6:0] ADDR_VDD    = 7'h2F;
   // Cycles after reset release before the strap is trusted
   localparam logic [1:0] STRAP_SETTLE = 2'h2;
   // Bits per byte on the wire
   localparam logic [3:0] BYTE_BITS   = 4'h8;

   // The two bus lines travel together
   typedef struct packed {
      logic scl;
      logic sda;
   } ldsr_lines_s;

   // Per-string fault view after masking
   typedef struct packed {
      logic ov;
      logic open;
      logic unused;
   } ldsr_string_s;

   // Transfer phase, Gray coded along start-byte-ack-send-master ack
   typedef enum logic [2:0] {
      PH_IDLE = 3'h0,
      PH_RX   = 3'h1,
      PH_ACK  = 3'h3,
      PH_TX   = 3'h2,
      PH_MACK = 3'h6
   } ldsr_phase_e;
endpackage : ldsr_pkg

// ---- core/ldsr_core.sv ----
/*
 Two-wire slave register interface of a four-string LED driver: measurement,
 string status, fault and peak current reference registers behind an SMBus port.
 Assumes level, status and fault inputs come from converter logic on CLK; the bus
 lines and the address strap come from pins and are synchronised here.
*/
`timescale 1ns/100ps
module ldsr_core (
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        SYS_RST,
   // Bus pins; open drain, only ever pulled low
   input  wire logic        SCL_I,
   input  wire logic        SDA_I,
   output logic             SDA_O,
   output logic             SDA_OE,
   // Address strap: 0 ground, 1 open, 2 supply
   input  wire logic [1:0]  ADDR_STRAP,
   // Measurements and raw string status from the analog side
   input  wire logic [31:0] DRAIN_LEVEL,
   input  wire logic [7:0]  ANODE_LEVEL,
   input  wire logic [3:0]  STRING_OVERVOLTAGE,
   input  wire logic [3:0]  STRING_OPENED,
   input  wire logic [7:0]  FAULT_STATE,
   // Controls toward the driver
   output logic [3:0]       STRING_UNUSED,
   output logic [7:0]       PEAK_CURRENT_REF,
   output logic [6:0]       OWN_ADDRESS
);
   ldsr_pkg::ldsr_lines_s  pin_meta_r, pin_sync_r, pin_prev_r;
   logic [1:0]             strap_meta_r, strap_sync_r, settle_r;
   logic                   strap_done_r;
   logic [6:0]             own_addr_r;
   ldsr_pkg::ldsr_phase_e  phase_r;
   logic [3:0]             bit_cnt_r;
   logic [7:0]             shift_r;
   logic [7:0]             tx_r;
   logic                   first_r, cmd_done_r, rd_r, oe_r;
   logic [3:0]             ptr_r;
   logic [3:0]             unused_r;
   logic [7:0]             peak_r;

   // Bus line synchronisers; the first stage feeds only the second
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         pin_meta_r <= '1;
         pin_sync_r <= '1;
         pin_prev_r <= '1;
      end else begin
         pin_meta_r <= '{scl: SCL_I, sda: SDA_I};
         pin_sync_r <= pin_meta_r;
         pin_prev_r <= pin_sync_r;
      end
   end

   // Edge and condition detection on the synchronised lines
   wire scl_rise = pin_sync_r.scl & ~pin_prev_r.scl;
   wire scl_fall = ~pin_sync_r.scl & pin_prev_r.scl;
   wire sda_bit  = pin_sync_r.sda;
   wire start_c  = pin_sync_r.scl & pin_prev_r.scl & pin_prev_r.sda & ~pin_sync_r.sda;
   wire stop_c   = pin_sync_r.scl & pin_prev_r.scl & ~pin_prev_r.sda & pin_sync_r.sda;

   // Strap pin synchroniser
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         strap_meta_r <= 2'h0;
         strap_sync_r <= 2'h0;
      end else begin
         strap_meta_r <= ADDR_STRAP;
         strap_sync_r <= strap_meta_r;
      end
   end

   // Strap decode; an illegal code falls back to the open address
   wire [6:0] strap_addr = (strap_sync_r == ldsr_pkg::STRAP_GND) ? ldsr_pkg::ADDR_GND :
                           (strap_sync_r == ldsr_pkg::STRAP_VDD) ? ldsr_pkg::ADDR_VDD :
                           ldsr_pkg::ADDR_OPEN;

   // Address caught once, after the synchroniser has filled with real pin levels
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         settle_r     <= 2'h0;
         strap_done_r <= 1'b0;
         own_addr_r   <= ldsr_pkg::ADDR_OPEN;
      end else if (!strap_done_r) begin
         settle_r <= settle_r + 2'h1;
         if (settle_r == ldsr_pkg::STRAP_SETTLE) begin
            own_addr_r   <= strap_addr;
            strap_done_r <= 1'b1;
         end
      end
   end

   // Per-string masked status; an unused string reports no fault
   ldsr_pkg::ldsr_string_s stat [4];
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_str
         assign stat[gi].ov     = STRING_OVERVOLTAGE[gi] & ~unused_r[gi];
         assign stat[gi].open   = STRING_OPENED[gi] & ~unused_r[gi];
         assign stat[gi].unused = unused_r[gi];
      end
   endgenerate

   // Status bytes: unused flags on top, then first string, then second
   wire [7:0] pair_a = {unused_r[0], unused_r[1], stat[0], stat[1]};
   wire [7:0] pair_b = {unused_r[2], unused_r[3], stat[2], stat[3]};

   // Read selection; unmapped indices read zero
   wire [7:0] rd_byte =
      (ptr_r <= ldsr_pkg::REG_DRAIN4) ? DRAIN_LEVEL[{ptr_r[1:0], 3'h0} +: 8] :
      (ptr_r == ldsr_pkg::REG_ANODE)  ? ANODE_LEVEL :
      (ptr_r == ldsr_pkg::REG_PAIR_A) ? pair_a :
      (ptr_r == ldsr_pkg::REG_PAIR_B) ? pair_b :
      (ptr_r == ldsr_pkg::REG_FAULT)  ? FAULT_STATE :
      (ptr_r == ldsr_pkg::REG_PEAK)   ? peak_r : 8'h00;

   // Byte just completed on this rising edge
   wire [7:0] rx_byte  = {shift_r[6:0], sda_bit};
   wire       last_bit = (bit_cnt_r == ldsr_pkg::BYTE_BITS - 4'h1);
   wire       wr_data  = (phase_r == ldsr_pkg::PH_RX) & scl_rise & last_bit & ~first_r & ~rd_r
                         & cmd_done_r;
   wire       addr_hit = (shift_r[7:1] == own_addr_r);

   // Writable state; only unused flags and the peak reference take bus data.
   // The write lands on the last data bit, ahead of the acknowledge.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         unused_r <= ldsr_pkg::RST_UNUSED;
         peak_r   <= ldsr_pkg::RST_PEAK;
      end else if (wr_data) begin
         if (ptr_r == ldsr_pkg::REG_PAIR_A) begin
            unused_r[0] <= rx_byte[ldsr_pkg::POS_FIRST_UNUSED];
            unused_r[1] <= rx_byte[ldsr_pkg::POS_SECOND_UNUSED];
         end
         if (ptr_r == ldsr_pkg::REG_PAIR_B) begin
            unused_r[2] <= rx_byte[ldsr_pkg::POS_FIRST_UNUSED];
            unused_r[3] <= rx_byte[ldsr_pkg::POS_SECOND_UNUSED];
         end
         if (ptr_r == ldsr_pkg::REG_PEAK)
            peak_r <= rx_byte;                                           // Others stay
      end
   end

   // Transfer engine; start and stop override any phase
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         phase_r    <= ldsr_pkg::PH_IDLE;
         bit_cnt_r  <= 4'h0;
         shift_r    <= 8'h00;
         tx_r       <= 8'h00;
         first_r    <= 1'b0;
         cmd_done_r <= 1'b0;
         rd_r       <= 1'b0;
         oe_r       <= 1'b0;
         ptr_r      <= 4'h0;
      end else if (start_c) begin
         phase_r    <= ldsr_pkg::PH_RX;
         bit_cnt_r  <= 4'h0;
         first_r    <= 1'b1;
         cmd_done_r <= 1'b0;
         rd_r       <= 1'b0;
         oe_r       <= 1'b0;
      end else if (stop_c) begin
         phase_r <= ldsr_pkg::PH_IDLE;
         oe_r    <= 1'b0;
      end else begin
         unique case (phase_r)
            ldsr_pkg::PH_IDLE: begin
               oe_r <= 1'b0;
            end
            ldsr_pkg::PH_RX: begin
               if (scl_rise) begin
                  shift_r   <= rx_byte;
                  bit_cnt_r <= bit_cnt_r + 4'h1;
                  if (last_bit & ~first_r & ~cmd_done_r) begin
                     ptr_r      <= rx_byte[3:0];
                     cmd_done_r <= 1'b1;
                  end else if (wr_data) begin
                     ptr_r <= ptr_r + 4'h1;                              // Word writes advance
                  end
               end else if (scl_fall && bit_cnt_r == ldsr_pkg::BYTE_BITS) begin
                  if (first_r && !addr_hit) begin
                     phase_r <= ldsr_pkg::PH_IDLE;
                  end else begin
                     if (first_r)
                        rd_r <= shift_r[0];
                     first_r <= 1'b0;
                     oe_r    <= 1'b1;
                     phase_r <= ldsr_pkg::PH_ACK;
                  end
               end
            end
            ldsr_pkg::PH_ACK: begin
               if (scl_fall) begin
                  bit_cnt_r <= 4'h0;
                  if (rd_r) begin
                     tx_r    <= rd_byte;
                     oe_r    <= ~rd_byte[7];
                     phase_r <= ldsr_pkg::PH_TX;
                  end else begin
                     oe_r    <= 1'b0;
                     phase_r <= ldsr_pkg::PH_RX;
                  end
               end
            end
            ldsr_pkg::PH_TX: begin
               if (scl_rise) begin
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end else if (scl_fall) begin
                  if (bit_cnt_r == ldsr_pkg::BYTE_BITS) begin
                     oe_r    <= 1'b0;                                    // Release for master ack
                     phase_r <= ldsr_pkg::PH_MACK;
                  end else begin
                     tx_r <= {tx_r[6:0], 1'b0};
                     oe_r <= ~tx_r[6];
                  end
               end
            end
            ldsr_pkg::PH_MACK: begin
               if (scl_rise) begin
                  if (sda_bit)
                     phase_r <= ldsr_pkg::PH_IDLE;
                  else
                     ptr_r <= ptr_r + 4'h1;                              // Read Word continues
               end else if (scl_fall) begin
                  bit_cnt_r <= 4'h0;
                  tx_r      <= rd_byte;
                  oe_r      <= ~rd_byte[7];
                  phase_r   <= ldsr_pkg::PH_TX;
               end
            end
            default: begin
               phase_r <= ldsr_pkg::PH_IDLE;
               oe_r    <= 1'b0;
            end
         endcase
      end
   end

   // Outputs; the data line is only ever pulled low
   assign SDA_O            = 1'b0;
   assign SDA_OE           = oe_r;
   assign STRING_UNUSED    = unused_r;
   assign PEAK_CURRENT_REF = peak_r;
   assign OWN_ADDRESS      = own_addr_r;
endmodule : ldsr_core

// ---- sim/ldsr_core_props.sv ----
/* Port checker of the LED driver serial status block.
 Assumes it is bound to ldsr_core and sees only that module's ports. */
`timescale 1ns/100ps
module ldsr_core_props (
   // Clock and reset
   input wire logic       CLK,
   input wire logic       SYS_RST,
   // Bus pins and strap
   input wire logic       SCL_I,
   input wire logic       SDA_O,
   input wire logic       SDA_OE,
   input wire logic [1:0] ADDR_STRAP,
   // Controls toward the driver
   input wire logic [3:0] STRING_UNUSED,
   input wire logic [7:0] PEAK_CURRENT_REF,
   input wire logic [6:0] OWN_ADDRESS
);
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   logic [3:0] up_r;
   // Cycles since release; strap capture is long over at 8
   always_ff @(posedge CLK)
      if (SYS_RST) up_r <= 4'h0;
      else if (up_r != 4'hF) up_r <= up_r + 4'h1;
   // Acknowledge follows a latched write within a byte tail
   sequence ack_soon;
      !SDA_OE ##[1:20] SDA_OE;
   endsequence
   a_reset_vals: assert property ($fell(SYS_RST) |-> !SDA_OE && STRING_UNUSED == 4'h0
      && PEAK_CURRENT_REF == 8'h7F) else $error("reset values wrong");
   a_drive_low: assert property (SDA_OE |-> SDA_O == 1'h0)
      else $error("data pin driven high");
   a_mask_ack: assert property ($changed(STRING_UNUSED) |-> ack_soon)
      else $error("mask not followed by acknowledge");
   a_write_ack: assert property ($changed(PEAK_CURRENT_REF) |-> ##[0:20] SDA_OE)
      else $error("write not acknowledged");
   a_change_low: assert property ($changed(SDA_OE) |-> !SCL_I || !$past(SCL_I))
      else $error("data moved with clock high");
   a_drive_held: assert property ($rose(SDA_OE) |-> SDA_OE[*4])
      else $error("low bit not held");
   a_addr_value: assert property (up_r == 4'h8 |-> OWN_ADDRESS == (ADDR_STRAP == 2'h0 ?
      7'h2C : ADDR_STRAP == 2'h2 ? 7'h2F : 7'h2E)) else $error("strap address wrong");
   a_addr_fixed: assert property (up_r > 4'h8 |-> $stable(OWN_ADDRESS))
      else $error("address moved after capture");
endmodule : ldsr_core_props
bind ldsr_core ldsr_core_props ldsr_core_props_i (.CLK(CLK), .SYS_RST(SYS_RST), .SCL_I(SCL_I),
   .SDA_O(SDA_O), .SDA_OE(SDA_OE), .ADDR_STRAP(ADDR_STRAP), .STRING_UNUSED(STRING_UNUSED),
   .PEAK_CURRENT_REF(PEAK_CURRENT_REF), .OWN_ADDRESS(OWN_ADDRESS));

// ---- sim/ldsr_host.sv ----
/* Two-wire bus master model timed by delays, 160 ns per bit.
 Assumes the bench feeds back the wired data line and calls tasks just after a CLK edge. */
`timescale 1ns/100ps
module ldsr_host (
   // Master lines; 1 means released to the pull-up
   output logic      scl,
   output logic      sda,
   // Wired data line
   input wire logic  sda_line
);
   // Clock stands high outside frames
   initial begin
      scl = 1'h1;
      sda = 1'h1;
   end
   // Bit slot: data moves mid low phase, sampled mid high phase
   task automatic bit_io(input logic b, output logic r);
      scl = 1'h0;
      #40 sda = b;
      #40 scl = 1'h1;
      #40 r = sda_line;
      #40;
   endtask : bit_io
   // Start or repeated start: data falls while clock high
   task automatic start();
      scl = 1'h0;
      #40 sda = 1'h1;
      #40 scl = 1'h1;
      #80 sda = 1'h0;
      #80;
   endtask : start
   // Stop: data rises while clock high
   task automatic stop();
      scl = 1'h0;
      #40 sda = 1'h0;
      #40 scl = 1'h1;
      #80 sda = 1'h1;
      #80;
   endtask : stop
   // Byte out MSB first; ak is 1 when the slave pulled the ninth bit low
   task automatic send(input logic [7:0] d, output logic ak);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'h1, r);
      ak = ~r;
   endtask : send
   // Byte in MSB first; the last one is refused to end the read
   task automatic recv(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'h1, d[i]);
      bit_io(last, r);
   endtask : recv
endmodule : ldsr_host

// ---- sim/test_ldsr_core.sv ----
/* Self-checking bench of the serial status block driven through a bus master model.
 Assumes package, core, checker and host model are compiled first. */
`timescale 1ns/100ps
module test_ldsr_core;
   logic        clk = 1'h0, rst = 1'h1, scl, sda_h, sda_o, sda_oe;
   logic [1:0]  strap = 2'h0;
   logic [31:0] drain = 32'h0, lf = 32'hCD58;
   logic [7:0]  anode = 8'h0, fault = 8'h0, pk, peak, wd[2], rd[2];
   logic [3:0]  ov = 4'h0, op = 4'h0, um, unused;
   logic [6:0]  own, adr;
   int          failures = 0, checks_done = 0, cyc = 0;
   wire         sda_line = sda_h & (sda_oe ? sda_o : 1'h1);  // Pull-up wins when released
   ldsr_core ldsr_core_i (.CLK(clk), .SYS_RST(rst), .SCL_I(scl), .SDA_I(sda_line),
      .SDA_O(sda_o), .SDA_OE(sda_oe), .ADDR_STRAP(strap), .DRAIN_LEVEL(drain),
      .ANODE_LEVEL(anode), .STRING_OVERVOLTAGE(ov), .STRING_OPENED(op), .FAULT_STATE(fault),
      .STRING_UNUSED(unused), .PEAK_CURRENT_REF(peak), .OWN_ADDRESS(own));
   ldsr_host ldsr_host_i (.scl(scl), .sda(sda_h), .sda_line(sda_line));
   // 50 MHz clock
   initial forever #10 clk = ~clk;
   // Hang guard, about twice the expected run length
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         failures++;
         complete_run();
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // Expected register byte; faults of unused strings are masked
   function automatic logic [7:0] exp_reg(input logic [3:0] r);
      logic [3:0] v, o;
      v = ov & ~um;
      o = op & ~um;
      case (r)
         4'h0, 4'h1, 4'h2, 4'h3: return drain[8 * r +: 8];
         4'h4: return anode;
         4'h5: return {um[0], um[1], v[0], o[0], um[0], v[1], o[1], um[1]};
         4'h6: return {um[2], um[3], v[2], o[2], um[2], v[3], o[3], um[3]};
         4'h7: return fault;
         4'h8: return pk;
         default: return 8'h00;
      endcase
   endfunction : exp_reg
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // Command plus nw data bytes, then nr bytes read after a (repeated) start
   task automatic xfer(input logic [6:0] a, input logic [7:0] c, input int nc, nw, nr, ea);
      logic k;
      int n;
      n = 0;
      if (nc > 0) begin
         ldsr_host_i.start();
         ldsr_host_i.send({a, 1'h0}, k);  // Write direction in the LSB
         n += k;
         ldsr_host_i.send(c, k);
         n += k;
         for (int i = 0; i < nw; i++) begin
            ldsr_host_i.send(wd[i], k);
            n += k;
         end
      end
      if (nr > 0) begin
         ldsr_host_i.start();
         ldsr_host_i.send({a, 1'h1}, k);  // Read direction in the LSB
         n += k;
         for (int i = 0; i < nr; i++) ldsr_host_i.recv(i == nr - 1, rd[i]);
      end
      ldsr_host_i.stop();
      chk("acknowledges", 8'(ea), 8'(n));
   endtask : xfer
   task automatic complete_run();
      if (failures == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : complete_run
   initial begin
      for (int s = 0; s < 3; s++) begin
         strap = 2'(s == 1 ? 2 : s == 2 ? 1 : 0);
         adr = s == 0 ? 7'h2C : s == 1 ? 7'h2F : 7'h2E;
         rst = 1'h1;
         repeat (8) @(posedge clk);
         #1 rst = 1'h0;
         um = 4'h0;
         pk = 8'h7F;
         repeat (10) @(posedge clk);
         #1 chk("own address", {1'h0, adr}, {1'h0, own});
         chk("peak reset", pk, peak);
      end
      for (int k = 0; k < 4; k++) begin
         lf = lfsr(lf);
         drain = lf;
         lf = lfsr(lf);
         {anode, fault, ov, op} = lf[23:0];
         lf = lfsr(lf);
         wd[0] = k == 0 ? 8'hFF : lf[7:0];
         xfer(adr, 8'h05, 1, 1, 0, 3);
         um[1:0] = {wd[0][6], wd[0][7]};
         wd[0] = lf[15:8];
         wd[1] = lf[23:16];
         xfer(adr, 8'h06, 1, 2, 0, 4);
         um[3:2] = {wd[0][6], wd[0][7]};
         chk("unused mask", {4'h0, um}, {4'h0, unused});
         wd[0] = lf[31:24];
         xfer(adr, 8'h08, 1, 1, 0, 3);
         pk = wd[0];
         chk("peak port", pk, peak);
         wd[0] = ~drain[7:0];
         xfer(adr, 8'h00, 1, 1, 0, 3);
         for (int r = 0; r < 10; r++) begin
            xfer(adr, 8'(r), 1, 0, 1, 3);
            chk("read byte", exp_reg(4'(r)), rd[0]);
         end
      end
      xfer(adr, 8'h05, 1, 0, 2, 3);
      chk("word low", exp_reg(4'h5), rd[0]);
      chk("word high", exp_reg(4'h6), rd[1]);
      xfer(adr, 8'h08, 1, 0, 0, 2);
      xfer(adr, 8'h00, 0, 0, 1, 1);
      chk("receive byte", pk, rd[0]);
      wd[0] = ~pk;
      xfer(adr ^ 7'h01, 8'h08, 1, 1, 0, 0);
      xfer(adr, 8'h08, 1, 0, 1, 3);
      chk("peak kept", pk, rd[0]);
      complete_run();
   end
endmodule : test_ldsr_core
